/* File: core/mif_irq_router.v */
// Interrupt routing, pin drive and free-fall detection for an inertial sensor
`timescale 1ns/1ps
// Operation
// - Free-fall events come only from accelerometer samples
// - Polarity bit selects asserted pin level
// - Drive bit selects push-pull or open-drain
// - Latched pin holds until source read
// - Unlatched signal drops with its condition
// - Pin A control mask bit map
// - Pin A motion mask bit map
// - Pin B control mask bit map
// - Pin B motion mask bit map
// - All routing bits reset to zero
// - Pin asserts on OR of routed signals
// - Merge bit puts everything on pin A
// - Source registers report each event cause
// - Free-fall when all axes stay in zone
// - Threshold code maps to fixed mg values
// - Duration is N accelerometer sample periods
// - Free-fall flag readable in wake source
// - Unlatched free-fall drops when condition ends
// - Latched routed free-fall cleared by read
// - Only routed events are latched
`include "mif_map.vh"

// ----------------------------------------
// Notes
// ----------------------------------------
// Magnitudes arrive unsigned in mg, so the zone test is full-scale free.
// Only the internal free-fall is latched here; outer detectors keep
// their own latches and clear them on the source read strobe.
// A new free-fall on the clearing read wins, so no event is lost.
// The duration counter saturates, so a long fall keeps the event up.
// Pins, enables and read data are flops, one cycle behind their inputs.
// Open-drain with active-low polarity relies on a board pull-up.
// Unmapped reads return zero; source registers are read-only.

module mif_irq_router (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Register port
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  // Accelerometer samples, magnitudes in mg
  input wire i_accel_valid,
  input wire [15:0] i_accel_x_mg,
  input wire [15:0] i_accel_y_mg,
  input wire [15:0] i_accel_z_mg,
  // Control-group event levels (bit map of pin A / pin B control masks)
  input wire [7:0] i_ctrl_evt_a,
  input wire [7:0] i_ctrl_evt_b,
  // Motion events other than free-fall (bit map of the motion masks)
  input wire [7:0] i_motion_evt_a,
  input wire [7:0] i_motion_evt_b,
  // Source register contents from outer detectors
  input wire [7:0] i_wake_src,
  input wire [7:0] i_orient_src,
  input wire [7:0] i_tap_source_reg,
  input wire [7:0] i_embedded_func_source_reg,
  // Interrupt pins
  output reg o_irq_pin_a,
  output reg o_irq_pin_a_oe_n,
  output reg o_irq_pin_b,
  output reg o_irq_pin_b_oe_n,
  // Source read strobes for outer latches
  output reg o_src_rd_pulse
);

// ----------------------------------------
// Configuration registers
// ----------------------------------------
// Stored configuration bytes
reg [7:0] control_reg_three_ff;
reg [7:0] control_reg_four_ff;
reg [7:0] pin_a_ctrl_mask_ff;
reg [7:0] pin_b_ctrl_mask_ff;
reg [7:0] pin_a_motion_mask_ff;
reg [7:0] pin_b_motion_mask_ff;
reg [7:0] tap_cfg_ff;
reg [7:0] free_fall_ff;
reg [7:0] wake_duration_reg_ff;

// Configuration fields
wire pin_polarity_low = control_reg_three_ff[`MIF_BIT_POL_LOW];
wire pin_drive_opendrain = control_reg_three_ff[`MIF_BIT_OPEN_DRAIN];
wire merge_pins_sel = control_reg_four_ff[`MIF_BIT_MERGE];
wire latch_irq_sel = tap_cfg_ff[`MIF_BIT_LATCH];
wire [2:0] fall_threshold_code = free_fall_ff[2:0];
wire [5:0] fall_duration_count = {wake_duration_reg_ff[`MIF_BIT_FF_DUR5],
                                  free_fall_ff[7:3]};

// Register writes; masks reset to zero
always @(posedge i_clk or negedge i_rst_n) begin
  if (!i_rst_n) begin
    control_reg_three_ff <= `MIF_RST_CFG;
    control_reg_four_ff <= `MIF_RST_CFG;
    pin_a_ctrl_mask_ff <= `MIF_RST_MASK;
    pin_b_ctrl_mask_ff <= `MIF_RST_MASK;
    pin_a_motion_mask_ff <= `MIF_RST_MASK;
    pin_b_motion_mask_ff <= `MIF_RST_MASK;
    tap_cfg_ff <= `MIF_RST_CFG;
    free_fall_ff <= `MIF_RST_CFG;
    wake_duration_reg_ff <= `MIF_RST_CFG;
  end else if (i_reg_wr) begin
    case (i_reg_addr)
      `MIF_ADDR_CTRL_THREE: control_reg_three_ff <= i_reg_wdata;
      `MIF_ADDR_CTRL_FOUR: control_reg_four_ff <= i_reg_wdata;
      `MIF_ADDR_PIN_A_CTRL: pin_a_ctrl_mask_ff <= i_reg_wdata;
      `MIF_ADDR_PIN_B_CTRL: pin_b_ctrl_mask_ff <= i_reg_wdata;
      `MIF_ADDR_PIN_A_MOTION: pin_a_motion_mask_ff <= i_reg_wdata;
      `MIF_ADDR_PIN_B_MOTION: pin_b_motion_mask_ff <= i_reg_wdata;
      `MIF_ADDR_TAP_CFG: tap_cfg_ff <= i_reg_wdata;
      `MIF_ADDR_FREE_FALL: free_fall_ff <= i_reg_wdata;
      `MIF_ADDR_WAKE_DUR: wake_duration_reg_ff <= i_reg_wdata;
      default: ;
    endcase
  end
end

// ----------------------------------------
// Free-fall detector
// ----------------------------------------
// Threshold, sample counter and free-fall condition
reg [15:0] ths_mg;
reg [5:0] fall_cnt_ff;
reg fall_cond_ff;
reg [5:0] nxt_fall_cnt;
reg nxt_fall_cond;

// Threshold lookup, same for every full scale
always @* begin
  case (fall_threshold_code)
    3'd0: ths_mg = `MIF_THS_0;
    3'd1: ths_mg = `MIF_THS_1;
    3'd2: ths_mg = `MIF_THS_2;
    3'd3: ths_mg = `MIF_THS_3;
    3'd4: ths_mg = `MIF_THS_4;
    3'd5: ths_mg = `MIF_THS_5;
    3'd6: ths_mg = `MIF_THS_6;
    default: ths_mg = `MIF_THS_7;
  endcase
end

// Inside the zone when every magnitude is under the threshold
wire in_zone = (i_accel_x_mg < ths_mg) && (i_accel_y_mg < ths_mg) &&
               (i_accel_z_mg < ths_mg);

// Count one bit wider so the top count never wraps to zero
wire [6:0] fall_cnt_inc = {1'b0, fall_cnt_ff} + 7'h01;
wire fall_dur_met = (fall_cnt_inc >= {1'b0, fall_duration_count});
// Saturate instead of wrapping, so a long fall never drops the event
wire fall_cnt_full = (fall_cnt_ff == 6'h3F);

// Count consecutive in-zone samples, one per sample period
always @* begin
  nxt_fall_cnt = fall_cnt_ff;
  nxt_fall_cond = fall_cond_ff;
  if (i_accel_valid) begin
    if (!in_zone) begin
      nxt_fall_cnt = 6'h00;
      nxt_fall_cond = 1'b0;
    end else begin
      if (!fall_cnt_full) begin
        nxt_fall_cnt = fall_cnt_inc[5:0];
      end
      nxt_fall_cond = fall_dur_met;
    end
  end
end

// Sample counter and condition flops
always @(posedge i_clk or negedge i_rst_n) begin
  if (!i_rst_n) begin
    fall_cnt_ff <= 6'h00;
    fall_cond_ff <= 1'b0;
  end else begin
    fall_cnt_ff <= nxt_fall_cnt;
    fall_cond_ff <= nxt_fall_cond;
  end
end

// ----------------------------------------
// Latch and routing
// ----------------------------------------
// Source register read decode
wire wake_src_rd = i_reg_rd && (i_reg_addr == `MIF_ADDR_WAKE_SRC);
wire orient_src_rd = i_reg_rd && (i_reg_addr == `MIF_ADDR_ORIENT_SRC);
wire tap_source_reg_rd = i_reg_rd && (i_reg_addr == `MIF_ADDR_TAP_SOURCE_REG);
wire embedded_func_source_reg_rd = i_reg_rd && (i_reg_addr == `MIF_ADDR_EMBEDDED_FUNC_SOURCE_REG);
wire any_src_rd = wake_src_rd | orient_src_rd | tap_source_reg_rd | embedded_func_source_reg_rd;
// Free-fall routed to at least one pin
wire fall_routed = pin_a_motion_mask_ff[`MIF_BIT_MOT_FALL] |
                   pin_b_motion_mask_ff[`MIF_BIT_MOT_FALL];
// Latch state and its next value
reg fall_latch_ff;
reg nxt_fall_latch;

// Latch free-fall only when routed; a new event wins over the clearing read
always @* begin
  nxt_fall_latch = fall_latch_ff;
  if (fall_cond_ff && latch_irq_sel && fall_routed) begin
    nxt_fall_latch = 1'b1;
  end else if (wake_src_rd || !latch_irq_sel) begin
    nxt_fall_latch = 1'b0;
  end
end

// Latch flop
always @(posedge i_clk or negedge i_rst_n) begin
  if (!i_rst_n) begin
    fall_latch_ff <= 1'b0;
  end else begin
    fall_latch_ff <= nxt_fall_latch;
  end
end

// ----------------------------------------
// Event vectors and routing
// ----------------------------------------
// Free-fall seen by the pins and the wake source flag
wire fall_evt = fall_cond_ff | fall_latch_ff;
// Motion vectors with the internal free-fall in bit 4
wire [7:0] mot_a = {i_motion_evt_a[7:5], fall_evt, i_motion_evt_a[3:0]};
wire [7:0] mot_b = {i_motion_evt_b[7:5], fall_evt, i_motion_evt_b[3:0]};
// Per-pin OR of routed signals
wire route_a = |(pin_a_ctrl_mask_ff & i_ctrl_evt_a) |
               |(pin_a_motion_mask_ff & mot_a);
wire route_b = |(pin_b_ctrl_mask_ff & i_ctrl_evt_b) |
               |(pin_b_motion_mask_ff & mot_b);
// Merge moves the pin B signals onto pin A
wire act_a = route_a | (merge_pins_sel & route_b);
wire act_b = route_b & ~merge_pins_sel;

// ----------------------------------------
// Pin drive and read data
// ----------------------------------------
// Pin levels ahead of the output flops
wire nxt_irq_pin_a = act_a ^ pin_polarity_low;
wire nxt_irq_pin_b = act_b ^ pin_polarity_low;
// Open-drain releases the pin in the rest state
wire nxt_irq_pin_a_oe_n = pin_drive_opendrain & ~act_a;
wire nxt_irq_pin_b_oe_n = pin_drive_opendrain & ~act_b;
// Source read strobe for the outer latches
wire nxt_src_rd_pulse = any_src_rd;

// Polarity and drive mode flops
always @(posedge i_clk or negedge i_rst_n) begin
  if (!i_rst_n) begin
    o_irq_pin_a <= 1'b0;
    o_irq_pin_b <= 1'b0;
    o_irq_pin_a_oe_n <= 1'b0;
    o_irq_pin_b_oe_n <= 1'b0;
    o_src_rd_pulse <= 1'b0;
  end else begin
    o_irq_pin_a <= nxt_irq_pin_a;
    o_irq_pin_b <= nxt_irq_pin_b;
    o_irq_pin_a_oe_n <= nxt_irq_pin_a_oe_n;
    o_irq_pin_b_oe_n <= nxt_irq_pin_b_oe_n;
    o_src_rd_pulse <= nxt_src_rd_pulse;
  end
end

// Read data next value
reg [7:0] nxt_reg_rdata;

// Read multiplexer; source registers report causes
always @* begin
  case (i_reg_addr)
    `MIF_ADDR_CTRL_THREE: nxt_reg_rdata = control_reg_three_ff;
    `MIF_ADDR_CTRL_FOUR: nxt_reg_rdata = control_reg_four_ff;
    `MIF_ADDR_PIN_A_CTRL: nxt_reg_rdata = pin_a_ctrl_mask_ff;
    `MIF_ADDR_PIN_B_CTRL: nxt_reg_rdata = pin_b_ctrl_mask_ff;
    `MIF_ADDR_PIN_A_MOTION: nxt_reg_rdata = pin_a_motion_mask_ff;
    `MIF_ADDR_PIN_B_MOTION: nxt_reg_rdata = pin_b_motion_mask_ff;
    `MIF_ADDR_TAP_CFG: nxt_reg_rdata = tap_cfg_ff;
    `MIF_ADDR_FREE_FALL: nxt_reg_rdata = free_fall_ff;
    `MIF_ADDR_WAKE_DUR: nxt_reg_rdata = wake_duration_reg_ff;
    `MIF_ADDR_WAKE_SRC: nxt_reg_rdata = {i_wake_src[7:6], fall_evt,
                                         i_wake_src[4:0]};
    `MIF_ADDR_ORIENT_SRC: nxt_reg_rdata = i_orient_src;
    `MIF_ADDR_TAP_SOURCE_REG: nxt_reg_rdata = i_tap_source_reg;
    `MIF_ADDR_EMBEDDED_FUNC_SOURCE_REG: nxt_reg_rdata = i_embedded_func_source_reg;
    default: nxt_reg_rdata = 8'h00;
  endcase
end

// Read data flop, holds until the next read
always @(posedge i_clk or negedge i_rst_n) begin
  if (!i_rst_n) begin
    o_reg_rdata <= 8'h00;
  end else if (i_reg_rd) begin
    o_reg_rdata <= nxt_reg_rdata;
  end
end

endmodule

/* File: core/mif_map.vh */
// Register offsets, field positions, reset values and threshold constants for the interrupt router
`ifndef MIF_MAP_VH
`define MIF_MAP_VH
// Register addresses (serial register port)
`define MIF_ADDR_CTRL_THREE 8'h12
`define MIF_ADDR_CTRL_FOUR 8'h13
`define MIF_ADDR_PIN_A_CTRL 8'h0D
`define MIF_ADDR_PIN_B_CTRL 8'h0E
`define MIF_ADDR_TAP_CFG 8'h58
`define MIF_ADDR_FREE_FALL 8'h5D
`define MIF_ADDR_WAKE_DUR 8'h5C
`define MIF_ADDR_PIN_A_MOTION 8'h5E
`define MIF_ADDR_PIN_B_MOTION 8'h5F
`define MIF_ADDR_WAKE_SRC 8'h1B
`define MIF_ADDR_ORIENT_SRC 8'h1D
`define MIF_ADDR_TAP_SOURCE_REG 8'h1C
`define MIF_ADDR_EMBEDDED_FUNC_SOURCE_REG 8'h53
// Reset values
`define MIF_RST_MASK 8'h00
`define MIF_RST_CFG 8'h00
// Field positions
`define MIF_BIT_POL_LOW 5
`define MIF_BIT_OPEN_DRAIN 4
`define MIF_BIT_MERGE 5
`define MIF_BIT_LATCH 0
`define MIF_BIT_FF_DUR5 7
`define MIF_BIT_FALL_FLAG 5
`define MIF_BIT_MOT_FALL 4
// Free-fall threshold in mg per code
`define MIF_THS_0 16'd156
`define MIF_THS_1 16'd219
`define MIF_THS_2 16'd250
`define MIF_THS_3 16'd312
`define MIF_THS_4 16'd344
`define MIF_THS_5 16'd406
`define MIF_THS_6 16'd469
`define MIF_THS_7 16'd500
`endif

/* File: sim/mif_irq_router_monitor.sv */
// Assertion checker for pin drive, routing and source-read strobes
`timescale 1ns/1ps
`include "mif_map.vh"
module mif_irq_monitor (
  // Clock, reset and register port
  input wire i_clk,
  input wire i_rst_n,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata,
  // Events and pins
  input wire [7:0] i_ctrl_evt_a,
  input wire o_irq_pin_a,
  input wire o_irq_pin_a_oe_n,
  input wire o_irq_pin_b,
  input wire o_irq_pin_b_oe_n,
  input wire o_src_rd_pulse
);
  reg [7:0] c3_ff, c4_ff, ma_ff;
  wire a_src = i_reg_addr == `MIF_ADDR_WAKE_SRC || i_reg_addr == `MIF_ADDR_TAP_SOURCE_REG
    || i_reg_addr == `MIF_ADDR_ORIENT_SRC || i_reg_addr == `MIF_ADDR_EMBEDDED_FUNC_SOURCE_REG;
  // Shadow copies of written configuration
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {c3_ff, c4_ff, ma_ff} <= 24'h00_0000;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `MIF_ADDR_CTRL_THREE) c3_ff <= i_reg_wdata;
      if (i_reg_addr == `MIF_ADDR_CTRL_FOUR) c4_ff <= i_reg_wdata;
      if (i_reg_addr == `MIF_ADDR_PIN_A_CTRL) ma_ff <= i_reg_wdata;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Configuration unchanged across the last edge
  sequence still;
    $stable(c3_ff) && $stable(c4_ff) && $stable(ma_ff);
  endsequence
  src_strobe_a: assert property (i_reg_rd && a_src |=> o_src_rd_pulse)
    else $error("source read gave no strobe");
  strobe_cause_a: assert property (o_src_rd_pulse |-> $past(i_reg_rd && a_src))
    else $error("strobe without source read");
  od_level_a: assert property (still ##0 c3_ff[4] && !o_irq_pin_a_oe_n |->
    o_irq_pin_a == !c3_ff[5]) else $error("pin a driven in released state");
  od_level_b_a: assert property (still ##0 c3_ff[4] && !o_irq_pin_b_oe_n |->
    o_irq_pin_b == !c3_ff[5]) else $error("pin b driven in released state");
  push_pull_a: assert property (still ##0 !c3_ff[4] |->
    !o_irq_pin_a_oe_n && !o_irq_pin_b_oe_n) else $error("push-pull pin not driven");
  merge_idle_a: assert property (still ##0 c4_ff[5] && !c3_ff[4] |->
    o_irq_pin_b == c3_ff[5]) else $error("pin b active while merged");
  ctrl_route_a: assert property (still ##0 |(ma_ff & $past(i_ctrl_evt_a)) |->
    o_irq_pin_a != c3_ff[5]) else $error("routed event missing on pin a");
  mask_read_a: assert property (i_reg_rd && i_reg_addr == `MIF_ADDR_PIN_A_CTRL |=>
    o_reg_rdata == $past(ma_ff)) else $error("pin a mask readback");
endmodule
bind mif_irq_router mif_irq_monitor u_mon (.*);

/* File: sim/mif_host_model.sv */
// Host processor model: register access and pin line resolution
`timescale 1ns/1ps
module mif_host_model (
  // Clock, read data and pins
  input wire i_clk,
  input wire [7:0] i_rdata,
  input wire i_pin_a,
  input wire i_pin_a_oe_n,
  input wire i_pin_b,
  input wire i_pin_b_oe_n,
  // Register port and resolved lines
  output reg o_wr,
  output reg o_rd,
  output reg [7:0] o_addr,
  output reg [7:0] o_wdata,
  output wire o_line_a,
  output wire o_line_b
);
  // Released lines rise through the board pull-up
  assign o_line_a = i_pin_a_oe_n ? 1'b1 : i_pin_a;
  assign o_line_b = i_pin_b_oe_n ? 1'b1 : i_pin_b;
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0_0000;
  // One-cycle write strobe
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge i_clk) #1;
      {o_wr, o_addr, o_wdata} = {1'b1, a, v};
      @(posedge i_clk) #1;
      o_wr = 1'b0;
    end
  endtask
  // Read strobe; a source read also clears latches
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge i_clk) #1;
      {o_rd, o_addr} = {1'b1, a};
      @(posedge i_clk) #1;
      o_rd = 1'b0;
      v = i_rdata;
    end
  endtask
endmodule

/* File: sim/mif_irq_router_tb_top.sv */
// Self-checking bench for the interrupt router and free-fall detector
`timescale 1ns/1ps
`include "mif_map.vh"
`define CHK(nm, e, s) begin samples_checked = samples_checked + 1; if ((e) !== (s)) begin \
  n_mismatch = n_mismatch + 1; $display("wrong value %s expected %h seen %h", nm, e, s); end end
module mif_irq_router_tb_top;
  reg clk = 0, rst_n = 0, av = 0;
  reg [15:0] x = 0, y = 0, z = 0, t;
  reg [31:0] evs = 0;
  reg [7:0] d;
  wire [7:0] rdata, addr, wdata;
  wire wr, rd, pa, pa_oe_n, pb, pb_oe_n, la, lb, srp;
  wire [31:0] ma = {`MIF_ADDR_PIN_B_MOTION, `MIF_ADDR_PIN_B_CTRL, `MIF_ADDR_PIN_A_MOTION,
    `MIF_ADDR_PIN_A_CTRL};
  wire [127:0] tv = {`MIF_THS_7, `MIF_THS_6, `MIF_THS_5, `MIF_THS_4, `MIF_THS_3, `MIF_THS_2,
    `MIF_THS_1, `MIF_THS_0};
  integer n_mismatch = 0, samples_checked = 0, cyc = 0, r, i;
  mif_irq_router u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_accel_valid(av),
    .i_accel_x_mg(x), .i_accel_y_mg(y), .i_accel_z_mg(z), .i_ctrl_evt_a(evs[7:0]),
    .i_motion_evt_a(evs[15:8]), .i_ctrl_evt_b(evs[23:16]), .i_motion_evt_b(evs[31:24]),
    .i_wake_src(8'h00), .i_orient_src(8'h00), .i_tap_source_reg(8'h00), .i_embedded_func_source_reg(8'h00),
    .o_irq_pin_a(pa), .o_irq_pin_a_oe_n(pa_oe_n), .o_irq_pin_b(pb),
    .o_irq_pin_b_oe_n(pb_oe_n), .o_src_rd_pulse(srp));
  mif_host_model u_host (.i_clk(clk), .i_rdata(rdata), .i_pin_a(pa), .i_pin_a_oe_n(pa_oe_n),
    .i_pin_b(pb), .i_pin_b_oe_n(pb_oe_n), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wdata), .o_line_a(la), .o_line_b(lb));
  always #5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end
  task close_out;
    begin
      if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task smp(input [15:0] a, input [15:0] b, input [15:0] c);
    begin
      {av, x, y, z} = {1'b1, a, b, c};
      step(1);
      av = 1'b0;
      step(1);
    end
  endtask
  task ffr(input e);
    begin
      u_host.rd(`MIF_ADDR_WAKE_SRC, d);
      `CHK("fall flag", e, d[5])
      `CHK("read strobe", 1'b1, srp)
    end
  endtask
  // Main sequence
  initial begin
    step(16);
    rst_n = 1'b1;
    for (r = 0; r < 4; r = r + 1) begin
      u_host.rd(ma[r*8 +: 8], d);
      `CHK("mask reset", 8'h00, d)
      u_host.wr(ma[r*8 +: 8], 8'hA5);
      u_host.rd(ma[r*8 +: 8], d);
      `CHK("mask rw", 8'hA5, d)
      u_host.wr(ma[r*8 +: 8], 8'h00);
    end
    for (r = 0; r < 4; r = r + 1) begin
      for (i = 0; i < 8; i = i + 1) if (!(r % 2 == 1 && i == 4)) begin
        u_host.wr(ma[r*8 +: 8], 8'h01 << i);
        evs = ~(32'h0000_0001 << (r * 8 + i));
        step(2);
        `CHK("unrouted", 2'b00, ({la, lb}))
        evs = 32'h0000_0001 << (r * 8 + i);
        step(2);
        `CHK("routed", (r < 2) ? 2'b10 : 2'b01, ({la, lb}))
      end
      u_host.wr(ma[r*8 +: 8], 8'h00);
    end
    u_host.wr(`MIF_ADDR_PIN_A_CTRL, 8'h01);
    u_host.wr(`MIF_ADDR_PIN_B_CTRL, 8'h01);
    evs = 32'h0000_0001;
    u_host.wr(`MIF_ADDR_CTRL_THREE, 8'h20);
    step(2);
    `CHK("low polarity", 2'b01, ({la, lb}))
    u_host.wr(`MIF_ADDR_CTRL_THREE, 8'h10);
    step(2);
    `CHK("open drain", 4'b1101, ({la, lb, pa_oe_n, pb_oe_n}))
    evs = 32'h0001_0001;
    step(2);
    `CHK("open drain on", 4'b1100, ({la, lb, pa_oe_n, pb_oe_n}))
    u_host.wr(`MIF_ADDR_CTRL_THREE, 8'h00);
    u_host.wr(`MIF_ADDR_CTRL_FOUR, 8'h20);
    evs = 32'h0001_0000;
    step(2);
    `CHK("merged", 2'b10, ({la, lb}))
    u_host.wr(`MIF_ADDR_CTRL_FOUR, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      u_host.wr(`MIF_ADDR_FREE_FALL, {5'd1, i[2:0]});
      t = tv[i*16 +: 16] - 16'h0001;
      smp(t, t, t);
      ffr(1'b1);
      smp(i % 3 == 0 ? t + 16'h0001 : t, i % 3 == 1 ? t + 16'h0001 : t,
        i % 3 == 2 ? t + 16'h0001 : t);
      ffr(1'b0);
    end
    u_host.wr(`MIF_ADDR_WAKE_DUR, 8'h80);
    u_host.wr(`MIF_ADDR_FREE_FALL, 8'h08);
    repeat (32) smp(16'h0000, 16'h0000, 16'h0000);
    smp(16'h0000, 16'h009C, 16'h0000);
    repeat (32) smp(16'h0000, 16'h0000, 16'h0000);
    ffr(1'b0);
    smp(16'h0000, 16'h0000, 16'h0000);
    ffr(1'b1);
    u_host.wr(`MIF_ADDR_WAKE_DUR, 8'h00);
    u_host.wr(`MIF_ADDR_TAP_CFG, 8'h01);
    u_host.wr(`MIF_ADDR_PIN_A_MOTION, 8'h10);
    smp(16'h0000, 16'h009C, 16'h0000);
    step(2);
    `CHK("latched pin", 1'b1, la)
    ffr(1'b1);
    step(2);
    `CHK("cleared pin", 1'b0, la)
    u_host.wr(`MIF_ADDR_PIN_A_MOTION, 8'h00);
    smp(16'h0000, 16'h0000, 16'h0000);
    smp(16'h0000, 16'h009C, 16'h0000);
    ffr(1'b0);
    close_out;
  end
endmodule
